// *** rtl/atl_threshold_lock.sv ***
// Overview of operation
// - Lower gain above reference plus eight plus up margin plus three plus down margin.
// - Strength level counts in 1.5 dB steps.
// - Load initial gain code when receive starts.
// - Gain never rises above initial gain code.
// - Raise gain below reference plus eight plus margin.
// - Reference level sets carrier sense and gain thresholds.
// - Monitor select routes constants, flags, clocks to pin.
// - Code four shows carrier sense, active low.
// - Lock window two or four prescaler cycles.
// - Count mode: restart or up/down counting.
// - Lock and unlock thresholds per accuracy select.
// - Gain control off holds initial gain code.
// - Average strength over 2, 4, 8, 16 samples.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
module atl_threshold_lock (
    input  wire logic                  clk_sys,       // 250 MHz system clock.
    input  wire logic                  srst,          // Synchronous reset, active high.
    input  wire atl_pkg::atl_apb_req_t apbReq,        // APB request from the host.
    output logic [31:0]                prdata,        // APB read data.
    output logic                       pready,        // APB ready.
    output logic                       pslverr,       // APB error on unmapped access.
    input  wire logic                  rxOn,          // Receive chain switched on.
    input  wire logic [7:0]            strengthLevel, // Filter magnitude, 1.5 dB steps.
    input  wire logic                  strengthValid, // Strength sample strobe.
    input  wire logic                  preTick,       // Prescaler clock cycle strobe.
    input  wire logic                  refEdge,       // Reference edge strobe.
    input  wire logic                  fbEdge,        // Divided oscillator edge strobe.
    input  wire logic                  calDone,       // Calibration finished.
    input  wire logic                  seqFault,      // Sequencing fault seen.
    input  wire logic [8:0]            monClocks,     // Clocks for select codes 7 to 15.
    output logic                       monitorPin,    // Monitor output pin.
    output logic [4:0]                 gainCode,      // Amplifier gain code.
    output logic                       carrierSense,  // Carrier present.
    output logic                       irq            // Level interrupt, active high.
);

    atl_pkg::atl_gain_down_reg_t gainDown_q;
    atl_pkg::atl_gain_up_reg_t   gainUp_q;
    atl_pkg::atl_lock_reg_t      lock_q;
    atl_pkg::atl_ctrl_reg_t      ctrl_q;
    logic [3:0]                  irqStat_q;
    logic [3:0]                  irqStat_d;
    logic [3:0]                  irqMask_q;
    logic [3:0]                  events;
    logic                        sustainedLock;
    logic                        instantLock;
    logic [9:0]                  lockCount;
    logic [4:0]                  gainRaw;
    logic [7:0]                  levelRaw;
    logic                        csRaw;
    logic                        lockPrev_q;
    logic                        csPrev_q;
    logic                        faultPrev_q;
    logic                        monitor_d;
    logic [7:0]                  regIdx;
    logic                        mapped;
    logic                        accessPhase;
    logic                        accessDone;
    logic                        wrDone;
    logic                        rdDone;
    logic [7:0]                  rdByte;
    localparam int APB_HI = atl_pkg::APB_ADDR_W - 1;

    // Decode of one register index against the address map.
    function automatic logic isMapped(input logic [7:0] idx);
        case (idx)
            atl_pkg::IDX_GAIN_DOWN,
            atl_pkg::IDX_GAIN_UP,
            atl_pkg::IDX_LOCK,
            atl_pkg::IDX_CTRL,
            atl_pkg::IDX_IRQ_STAT,
            atl_pkg::IDX_IRQ_MASK,
            atl_pkg::IDX_STATE: isMapped = 1'b1;
            default:            isMapped = 1'b0;
        endcase
    endfunction : isMapped

    // APB decode. Every register is one aligned word; misaligned addresses are errors.
    assign regIdx      = apbReq.paddr[9:2];
    assign mapped      = isMapped(regIdx) && apbReq.paddr[1:0] == 2'h0
                         && apbReq.paddr[APB_HI:10] == '0;
    assign accessPhase = apbReq.psel & apbReq.penable;
    assign accessDone  = accessPhase & pready;
    assign wrDone      = accessDone & apbReq.pwrite & ~pslverr;
    assign rdDone      = accessDone & ~apbReq.pwrite & ~pslverr;

    // Ready is registered, so every transfer takes exactly one wait state.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= accessPhase & ~pready;
        end
    end

    always_comb begin
        case (regIdx)
            atl_pkg::IDX_GAIN_DOWN: rdByte = gainDown_q;
            atl_pkg::IDX_GAIN_UP:   rdByte = gainUp_q;
            atl_pkg::IDX_LOCK:      rdByte = lock_q;
            atl_pkg::IDX_CTRL:      rdByte = {5'h00, ctrl_q.autoGainOff,
                                              ctrl_q.magnitudeAverageLen};
            atl_pkg::IDX_IRQ_STAT:  rdByte = {4'h0, irqStat_q};
            atl_pkg::IDX_IRQ_MASK:  rdByte = {4'h0, irqMask_q};
            atl_pkg::IDX_STATE:     rdByte = {csRaw, instantLock, sustainedLock, gainRaw};
            default:                rdByte = 8'h00;
        endcase
    end

    // Read data and error are captured in the first access cycle and held for the second.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (accessPhase && !pready) begin
            prdata  <= apbReq.pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
            pslverr <= ~mapped;
        end else if (!accessPhase) begin
            pslverr <= 1'b0;
        end
    end

    // Configuration registers; new fields steer the very next comparison.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gainDown_q <= atl_pkg::RST_GAIN_DOWN;
            gainUp_q   <= atl_pkg::RST_GAIN_UP;
            lock_q     <= atl_pkg::RST_LOCK;
            ctrl_q     <= atl_pkg::RST_CTRL;
        end else if (wrDone) begin
            case (regIdx)
                atl_pkg::IDX_GAIN_DOWN: gainDown_q <= apbReq.pwdata[7:0];
                atl_pkg::IDX_GAIN_UP:   gainUp_q   <= apbReq.pwdata[7:0];
                atl_pkg::IDX_LOCK:      lock_q     <= apbReq.pwdata[7:0];
                atl_pkg::IDX_CTRL:      ctrl_q     <= {5'h00, apbReq.pwdata[2:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqMask_q <= atl_pkg::RST_IRQ_MASK;
        end else if (wrDone && regIdx == atl_pkg::IDX_IRQ_MASK) begin
            irqMask_q <= apbReq.pwdata[3:0];
        end
    end

    atl_gain_ctrl u_gain (
        .clk_sys       (clk_sys),
        .srst          (srst),
        .rxOn          (rxOn),
        .strengthIn    (strengthLevel),
        .strengthValid (strengthValid),
        .autoGainOff   (ctrl_q.autoGainOff),
        .avgLenSel     (ctrl_q.magnitudeAverageLen),
        .downCfg       (gainDown_q),
        .upCfg         (gainUp_q),
        .gainCode      (gainRaw),
        .level         (levelRaw),
        .carrierSense  (csRaw)
    );

    atl_lock_detect u_lock (
        .clk_sys       (clk_sys),
        .srst          (srst),
        .preTick       (preTick),
        .refEdge       (refEdge),
        .fbEdge        (fbEdge),
        .windowWide    (lock_q.lockWindowSize),
        .upDownMode    (lock_q.detectorCountMode),
        .thrSel        (lock_q.lockThresholdSelect),
        .sustainedLock (sustainedLock),
        .instantLock   (instantLock),
        .lockCount     (lockCount)
    );

    // Event detection for the interrupt status register.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lockPrev_q  <= 1'b0;
            csPrev_q    <= 1'b0;
            faultPrev_q <= 1'b0;
        end else begin
            lockPrev_q  <= sustainedLock;
            csPrev_q    <= csRaw;
            faultPrev_q <= seqFault;
        end
    end

    always_comb begin
        events                           = 4'h0;
        events[atl_pkg::IRQ_LOCK_GAINED] = sustainedLock & ~lockPrev_q;
        events[atl_pkg::IRQ_LOCK_LOST]   = ~sustainedLock & lockPrev_q;
        events[atl_pkg::IRQ_CARRIER]     = csRaw & ~csPrev_q;
        events[atl_pkg::IRQ_SEQ_FAULT]   = seqFault & ~faultPrev_q;
    end

    // A read clears the status, but an event in the same cycle survives the clear.
    always_comb begin
        irqStat_d = irqStat_q;
        if (rdDone && regIdx == atl_pkg::IDX_IRQ_STAT) begin
            irqStat_d = 4'h0;
        end
        irqStat_d = irqStat_d | events;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqStat_q <= 4'h0;
            irq       <= 1'b0;
        end else begin
            irqStat_q <= irqStat_d;
            irq       <= |(irqStat_d & irqMask_q);
        end
    end

    // Monitor pin mux. Status flags are inverted because the pin shows them active low.
    always_comb begin
        case (lock_q.monitorPinSelect)
            atl_pkg::MON_LOW:       monitor_d = 1'b0;
            atl_pkg::MON_HIGH:      monitor_d = 1'b1;
            atl_pkg::MON_SUSTAINED: monitor_d = ~sustainedLock;
            atl_pkg::MON_INSTANT:   monitor_d = ~instantLock;
            atl_pkg::MON_CARRIER:   monitor_d = ~csRaw;
            atl_pkg::MON_CAL_DONE:  monitor_d = ~calDone;
            atl_pkg::MON_SEQ_FAULT: monitor_d = ~seqFault;
            default:                monitor_d = monClocks[lock_q.monitorPinSelect
                                                          - atl_pkg::MON_CLK_FIRST];
        endcase
    end

    // The pin is registered, so routed clocks appear one cycle late and at most
    // at half the system rate; that is the price of a glitch-free output.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            monitorPin   <= 1'b0;
            gainCode     <= atl_pkg::RST_GAIN_CODE;
            carrierSense <= 1'b0;
        end else begin
            monitorPin   <= monitor_d;
            gainCode     <= gainRaw;
            carrierSense <= csRaw;
        end
    end

endmodule : atl_threshold_lock

// *** rtl/atl_pkg.sv ***
package atl_pkg;

    // Register indices; the byte address of a register is four times its index.
    localparam logic [7:0] IDX_GAIN_DOWN = 8'h13;
    localparam logic [7:0] IDX_GAIN_UP   = 8'h14;
    localparam logic [7:0] IDX_LOCK      = 8'h15;
    localparam logic [7:0] IDX_CTRL      = 8'h20;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h21;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h22;
    localparam logic [7:0] IDX_STATE     = 8'h23;

    localparam int          APB_ADDR_W   = 12;
    localparam logic [7:0]  RST_GAIN_DOWN = 8'h38;
    localparam logic [7:0]  RST_GAIN_UP   = 8'h38;
    localparam logic [7:0]  RST_LOCK      = 8'h00;
    localparam logic [7:0]  RST_CTRL      = 8'h01;
    localparam logic [3:0]  RST_IRQ_MASK  = 4'h0;
    localparam logic [4:0]  RST_GAIN_CODE = 5'h18;

    // Strength scale: one step of the internal level is 1500 millidecibel.
    localparam int          STRENGTH_STEP_MDB = 1500;
    localparam logic [7:0]  UP_BASE_OFFSET    = 8'h08;
    localparam logic [7:0]  DOWN_BASE_OFFSET  = 8'h03;
    localparam logic [2:0]  WIN_NARROW        = 3'h2;
    localparam logic [2:0]  WIN_WIDE          = 3'h4;
    localparam logic [9:0]  LOCK_CNT_MAX      = 10'h3ff;

    // Monitor pin select codes with a fixed meaning.
    localparam logic [3:0]  MON_LOW       = 4'h0;
    localparam logic [3:0]  MON_HIGH      = 4'h1;
    localparam logic [3:0]  MON_SUSTAINED = 4'h2;
    localparam logic [3:0]  MON_INSTANT   = 4'h3;
    localparam logic [3:0]  MON_CARRIER   = 4'h4;
    localparam logic [3:0]  MON_CAL_DONE  = 4'h5;
    localparam logic [3:0]  MON_SEQ_FAULT = 4'h6;
    localparam logic [3:0]  MON_CLK_FIRST = 4'h7;

    // Interrupt status bit positions.
    localparam int IRQ_LOCK_GAINED = 0;
    localparam int IRQ_LOCK_LOST   = 1;
    localparam int IRQ_CARRIER     = 2;
    localparam int IRQ_SEQ_FAULT   = 3;

    typedef struct packed {
        logic [2:0] gainDownMargin;
        logic [4:0] initialGainCode;
    } atl_gain_down_reg_t;

    typedef struct packed {
        logic [2:0] gainUpMargin;
        logic [4:0] signalReferenceLevel;
    } atl_gain_up_reg_t;

    typedef struct packed {
        logic [3:0] monitorPinSelect;
        logic       lockWindowSize;
        logic       detectorCountMode;
        logic [1:0] lockThresholdSelect;
    } atl_lock_reg_t;

    typedef struct packed {
        logic [4:0] reserved;
        logic       autoGainOff;
        logic [1:0] magnitudeAverageLen;
    } atl_ctrl_reg_t;

    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [APB_ADDR_W-1:0] paddr;
        logic [31:0]           pwdata;
    } atl_apb_req_t;

    function automatic logic [9:0] lockOnThr(input logic [1:0] sel);
        case (sel)
            2'h0:    lockOnThr = 10'h07f;
            2'h1:    lockOnThr = 10'h0ff;
            2'h2:    lockOnThr = 10'h1ff;
            default: lockOnThr = 10'h3ff;
        endcase
    endfunction : lockOnThr

    function automatic logic [9:0] lockOffThr(input logic [1:0] sel);
        case (sel)
            2'h0:    lockOffThr = 10'h06f;
            2'h1:    lockOffThr = 10'h0ef;
            2'h2:    lockOffThr = 10'h1ef;
            default: lockOffThr = 10'h3ef;
        endcase
    endfunction : lockOffThr

endpackage : atl_pkg

// *** rtl/atl_lock_detect.sv ***
`timescale 1ns/1ns
module atl_lock_detect (
    input  wire logic       clk_sys,        // System clock.
    input  wire logic       srst,           // Synchronous reset.
    input  wire logic       preTick,        // One prescaler clock cycle elapsed.
    input  wire logic       refEdge,        // Reference clock edge.
    input  wire logic       fbEdge,         // Divided oscillator edge.
    input  wire logic       windowWide,     // Window width select.
    input  wire logic       upDownMode,     // Counting mode select.
    input  wire logic [1:0] thrSel,         // Lock threshold select.
    output logic            sustainedLock,  // Lock held by counter.
    output logic            instantLock,    // Last comparison inside window.
    output logic [9:0]      lockCount       // Lock counter value.
);

    typedef enum logic [1:0] {ST_IDLE, ST_REF_FIRST, ST_FB_FIRST} atl_lock_state_t;

    atl_lock_state_t state_q;
    logic [2:0]      gap_q;
    logic [2:0]      window;
    logic            cmpValid;
    logic            cmpInside;

    assign window = windowWide ? atl_pkg::WIN_WIDE : atl_pkg::WIN_NARROW;

    always_comb begin
        cmpValid  = 1'b0;
        cmpInside = 1'b0;
        case (state_q)
            ST_IDLE: begin
                cmpValid  = refEdge & fbEdge;
                cmpInside = 1'b1;
            end
            ST_REF_FIRST, ST_FB_FIRST: begin
                if ((state_q == ST_REF_FIRST) ? fbEdge : refEdge) begin
                    cmpValid  = 1'b1;
                    cmpInside = gap_q < window;
                end else if (gap_q >= window) begin
                    cmpValid  = 1'b1;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_IDLE;
            gap_q   <= 3'h0;
        end else if (cmpValid || state_q == ST_IDLE) begin
            gap_q   <= 3'h0;
            state_q <= ST_IDLE;
            if (!cmpValid && refEdge) begin
                state_q <= ST_REF_FIRST;
            end else if (!cmpValid && fbEdge) begin
                state_q <= ST_FB_FIRST;
            end
        end else if (preTick) begin
            gap_q <= gap_q + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lockCount   <= 10'h000;
            instantLock <= 1'b0;
        end else if (cmpValid) begin
            instantLock <= cmpInside;
            if (cmpInside) begin
                if (lockCount != atl_pkg::LOCK_CNT_MAX) begin
                    lockCount <= lockCount + 10'h001;
                end
            end else if (upDownMode) begin
                if (lockCount != 10'h000) begin
                    lockCount <= lockCount - 10'h001;
                end
            end else begin
                lockCount <= 10'h000;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sustainedLock <= 1'b0;
        end else if (lockCount >= atl_pkg::lockOnThr(thrSel)) begin
            sustainedLock <= 1'b1;
        end else if (lockCount <= atl_pkg::lockOffThr(thrSel)) begin
            sustainedLock <= 1'b0;
        end
    end

endmodule : atl_lock_detect

// *** rtl/atl_gain_ctrl.sv ***
`timescale 1ns/1ns
module atl_gain_ctrl (
    input  wire logic                         clk_sys,       // System clock.
    input  wire logic                         srst,          // Synchronous reset.
    input  wire logic                         rxOn,          // Receive chain powered.
    input  wire logic [7:0]                   strengthIn,    // Sample, 1.5 dB steps.
    input  wire logic                         strengthValid, // Sample strobe.
    input  wire logic                         autoGainOff,   // Hold gain at initial code.
    input  wire logic [1:0]                   avgLenSel,     // Average length select.
    input  wire atl_pkg::atl_gain_down_reg_t  downCfg,       // Down margin, initial gain.
    input  wire atl_pkg::atl_gain_up_reg_t    upCfg,         // Up margin, reference.
    output logic [4:0]                        gainCode,      // Amplifier gain.
    output logic [7:0]                        level,         // Averaged strength.
    output logic                              carrierSense   // Level above reference.
);

    logic [11:0] accum_q;
    logic [4:0]  cnt_q;
    logic        levelValid_q;
    logic [11:0] sum;
    logic [7:0]  upThr;
    logic [7:0]  downThr;
    logic [4:0]  ceiling;

    assign sum     = accum_q + {4'h0, strengthIn};
    assign ceiling = downCfg.initialGainCode;
    assign upThr   = {3'h0, upCfg.signalReferenceLevel} + atl_pkg::UP_BASE_OFFSET
                     + {5'h00, upCfg.gainUpMargin};
    assign downThr = upThr + atl_pkg::DOWN_BASE_OFFSET + {5'h00, downCfg.gainDownMargin};

    // Level is kept in 1.5 dB steps, so the thresholds add as plain integers.
    always_ff @(posedge clk_sys) begin
        if (srst || !rxOn) begin
            accum_q      <= 12'h000;
            cnt_q        <= 5'h00;
            level        <= 8'h00;
            levelValid_q <= 1'b0;
        end else begin
            levelValid_q <= 1'b0;
            if (strengthValid) begin
                if (cnt_q + 5'h01 == 5'(5'h02 << avgLenSel)) begin
                    level        <= 8'(sum >> ({2'h0, avgLenSel} + 3'h1));
                    levelValid_q <= 1'b1;
                    accum_q      <= 12'h000;
                    cnt_q        <= 5'h00;
                end else begin
                    accum_q <= sum;
                    cnt_q   <= cnt_q + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || !rxOn) begin
            carrierSense <= 1'b0;
        end else if (levelValid_q) begin
            carrierSense <= level > {3'h0, upCfg.signalReferenceLevel};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gainCode <= atl_pkg::RST_GAIN_CODE;
        end else if (!rxOn || autoGainOff) begin
            gainCode <= ceiling;
        end else if (gainCode > ceiling) begin
            gainCode <= ceiling;
        end else if (levelValid_q) begin
            if (level > downThr && gainCode != 5'h00) begin
                gainCode <= gainCode - 5'h01;
            end else if (level < upThr && gainCode < ceiling) begin
                gainCode <= gainCode + 5'h01;
            end
        end
    end

endmodule : atl_gain_ctrl

// *** dv/atl_threshold_lock_chk.sv ***
`timescale 1ns/1ns
module atl_threshold_lock_chk (
    input wire logic                  clk_sys,       // Clock.
    input wire logic                  srst,          // Reset.
    input wire atl_pkg::atl_apb_req_t apbReq,        // APB request.
    input wire logic                  pready,        // Ready.
    input wire logic                  pslverr,       // Error.
    input wire logic                  rxOn,          // Receive on.
    input wire logic                  strengthValid, // Sample strobe.
    input wire logic                  monitorPin,    // Monitor pin.
    input wire logic [4:0]            gainCode,      // Gain.
    input wire logic                  carrierSense,  // Carrier.
    input wire logic                  irq            // Interrupt.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire acc = apbReq.psel && apbReq.penable;
    // Five quiet cycles cover the two-stage gain pipeline after the last write.
    sequence quietRx; (!rxOn && !pready) [*5]; endsequence
    a_ready_wait: assert property (acc && !pready |=> pready)
        else $error("ready missing after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(acc))
        else $error("ready without access phase");
    a_err_access: assert property ($rose(pslverr) |-> $past(acc))
        else $error("error outside a transfer");
    a_reset_outputs: assert property ($fell(srst) |->
        gainCode == atl_pkg::RST_GAIN_CODE && !monitorPin && !irq && !carrierSense)
        else $error("wrong outputs after reset");
    a_carrier_rxoff: assert property (!rxOn [*3] |-> !carrierSense)
        else $error("carrier while receive off");
    a_carrier_cause: assert property ($rose(carrierSense) |->
        $past(strengthValid, 2) || $past(strengthValid, 3) || $past(strengthValid, 4))
        else $error("carrier rose without a sample");
    a_gain_hold: assert property (quietRx |-> $stable(gainCode))
        else $error("gain moved while receive off");
endmodule : atl_threshold_lock_chk

// *** dv/atl_host_bfm.sv ***
`timescale 1ns/1ns
module atl_host_bfm (
    input  wire logic             clk_sys, // Clock.
    output atl_pkg::atl_apb_req_t apbReq,  // APB request.
    input  wire logic [31:0]      prdata,  // Read data.
    input  wire logic             pready,  // Ready.
    input  wire logic             pslverr  // Error.
);
    initial apbReq = '0;
    // The request stands until ready is seen at an edge, so slow answers are honoured.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic err);
        @(posedge clk_sys);
        apbReq <= '{1'b1, 1'b0, w, {2'h0, idx, 2'h0}, {24'h0, wd}};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do @(posedge clk_sys); while (!pready);
        rd = prdata[7:0];
        err = pslverr;
        apbReq <= '0;
    endtask : xfer
endmodule : atl_host_bfm

// *** dv/atl_threshold_lock_test.sv ***
`timescale 1ns/1ns
module atl_threshold_lock_test;
    logic clk_sys = 1'b0, srst = 1'b1, rxOn = 1'b0, strengthValid = 1'b0, preTick = 1'b0;
    logic refEdge = 1'b0, fbEdge = 1'b0, calDone = 1'b1, seqFault = 1'b0;
    logic [7:0] strengthLevel = 8'h00;
    logic [8:0] monClocks = 9'h000;
    logic [31:0] prdata;
    logic pready, pslverr, monitorPin, carrierSense, irq;
    logic [4:0] gainCode;
    wire atl_pkg::atl_apb_req_t apbReq;
    int errors = 0, checkCount = 0;
    always #2 clk_sys = ~clk_sys;
    atl_host_bfm atl_host_bfm_i (.clk_sys(clk_sys), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    atl_threshold_lock atl_threshold_lock_i (.clk_sys(clk_sys), .srst(srst), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxOn(rxOn),
        .strengthLevel(strengthLevel), .strengthValid(strengthValid), .preTick(preTick),
        .refEdge(refEdge), .fbEdge(fbEdge), .calDone(calDone), .seqFault(seqFault),
        .monClocks(monClocks), .monitorPin(monitorPin), .gainCode(gainCode),
        .carrierSense(carrierSense), .irq(irq));
    task automatic tick(input int n); repeat (n) @(posedge clk_sys); endtask : tick
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        atl_host_bfm_i.xfer(1'b1, idx, d, r, e);
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [8:0] exp);
        logic [7:0] r;
        logic e;
        atl_host_bfm_i.xfer(1'b0, idx, 8'h00, r, e);
        chk({e, r}, exp);
    endtask : rdc
    task automatic pin(input logic [3:0] s, input logic e);
        wr(atl_pkg::IDX_LOCK, {s, 4'h0});
        tick(4);
        chk(monitorPin, e);
    endtask : pin
    task automatic pairs(input int n);
        repeat (n) begin refEdge <= 1'b1; fbEdge <= 1'b1; tick(1); end
        refEdge <= 1'b0;
        fbEdge <= 1'b0;
        tick(4);
    endtask : pairs
    task automatic gap(input int p);
        refEdge <= 1'b1;
        tick(1);
        refEdge <= 1'b0;
        preTick <= 1'b1;
        tick(p);
        preTick <= 1'b0;
        tick(4);
    endtask : gap
    task automatic smp2(input logic [7:0] v, input logic [4:0] g);
        strengthLevel <= v;
        strengthValid <= 1'b1;
        tick(2);
        strengthValid <= 1'b0;
        tick(6);
        chk(gainCode, g);
    endtask : smp2
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    initial begin
        tick(16);
        srst <= 1'b0;
        rdc(atl_pkg::IDX_GAIN_DOWN, 9'h038);
        rdc(atl_pkg::IDX_GAIN_UP, 9'h038);
        rdc(atl_pkg::IDX_LOCK, 9'h000);
        wr(atl_pkg::IDX_LOCK, 8'ha5);
        rdc(atl_pkg::IDX_LOCK, 9'h0a5);
        rdc(8'h30, 9'h100);
        $display("registers done");
        pin(atl_pkg::MON_LOW, 1'b0);
        pin(atl_pkg::MON_HIGH, 1'b1);
        pin(atl_pkg::MON_CAL_DONE, 1'b0);
        pin(atl_pkg::MON_SEQ_FAULT, 1'b1);
        pin(atl_pkg::MON_INSTANT, 1'b1);
        for (int c = 0; c < 9; c++) begin
            monClocks <= 9'h001 << c;
            pin(4'h7 + 4'(c), 1'b1);
        end
        $display("monitor done");
        wr(atl_pkg::IDX_IRQ_MASK, 8'h01);
        pin(atl_pkg::MON_SUSTAINED, 1'b1);
        pairs(126);
        chk(monitorPin, 1'b1);
        pairs(1);
        chk({monitorPin, irq}, 2'b01);
        rdc(atl_pkg::IDX_IRQ_STAT, 9'h001);
        tick(2);
        chk(irq, 1'b0);
        wr(atl_pkg::IDX_LOCK, 8'h2c);
        gap(2);
        rdc(atl_pkg::IDX_STATE, 9'h078);
        gap(2);
        chk(monitorPin, 1'b0);
        wr(atl_pkg::IDX_LOCK, 8'h20);
        gap(2);
        chk(monitorPin, 1'b1);
        $display("lock done");
        wr(atl_pkg::IDX_GAIN_DOWN, 8'h18);
        wr(atl_pkg::IDX_GAIN_UP, 8'h0a);
        wr(atl_pkg::IDX_CTRL, 8'h00);
        wr(atl_pkg::IDX_LOCK, {atl_pkg::MON_CARRIER, 4'h0});
        rxOn <= 1'b1;
        smp2(8'h1e, 5'h17);
        chk({carrierSense, monitorPin}, 2'b10);
        smp2(8'h16, 5'h16);
        smp2(8'h15, 5'h16);
        smp2(8'h11, 5'h17);
        wr(atl_pkg::IDX_CTRL, 8'h04);
        tick(4);
        chk(gainCode, 5'h18);
        wr(atl_pkg::IDX_CTRL, 8'h00);
        smp2(8'h05, 5'h18);
        rxOn <= 1'b0;
        tick(4);
        chk(carrierSense, 1'b0);
        $display("gain done");
        give_verdict();
    end
    initial begin
        tick(20000);
        errors++;
        give_verdict();
    end
endmodule : atl_threshold_lock_test
bind atl_threshold_lock atl_threshold_lock_chk atl_threshold_lock_chk_i (.clk_sys(clk_sys),
    .srst(srst), .apbReq(apbReq), .pready(pready), .pslverr(pslverr), .rxOn(rxOn),
    .strengthValid(strengthValid), .monitorPin(monitorPin), .gainCode(gainCode),
    .carrierSense(carrierSense), .irq(irq));
